// [verilog/inc_pkg.sv]
// Shared constants for the inclinometer serial port: frame layout,
// result register map and link timing.
// Assumes a 125 MHz core clock and a host-made serial clock.

package inc_pkg;

    // ****************************************************
    // Frame layout
    // ****************************************************
    localparam int INC_FRAME_BITS = 16;
    localparam int INC_CNT_W = 5;
    localparam logic [INC_CNT_W-1:0] INC_FRAME_CNT = 5'h10;
    localparam logic [INC_CNT_W-1:0] INC_LAST_CNT = 5'h0f;
    localparam logic [3:0] INC_MSB_IDX = 4'hf;
    localparam int INC_ADDR_W = 6;
    localparam int INC_BYTE_W = 8;
    localparam int INC_CMD_WR_BIT = 15;
    localparam int INC_CMD_MODE_BIT = 14;
    localparam int INC_ADDR_HI = 13;
    localparam int INC_ADDR_LO = 8;

    // ****************************************************
    // Result registers
    // ****************************************************
    localparam int INC_NUM_RES = 5;
    localparam int INC_DATA_W = 14;
    localparam int INC_NARROW_W = 12;
    localparam int INC_FRESH_BIT = 15;
    localparam int INC_ALARM_BIT = 14;
    typedef logic [INC_ADDR_W-1:0] inc_addr_t;
    localparam inc_addr_t INC_ADDR_SUPPLY = 6'h02;
    localparam inc_addr_t INC_ADDR_AUX = 6'h08;
    localparam inc_addr_t INC_ADDR_TEMP = 6'h0a;
    localparam inc_addr_t INC_ADDR_FULL_ANGLE = 6'h0c;
    localparam inc_addr_t INC_ADDR_HALF_ANGLE = 6'h0e;
    localparam inc_addr_t INC_RES_ADDR [INC_NUM_RES] = '{
        INC_ADDR_SUPPLY, INC_ADDR_AUX, INC_ADDR_TEMP,
        INC_ADDR_FULL_ANGLE, INC_ADDR_HALF_ANGLE};
    localparam int INC_RES_WIDTH [INC_NUM_RES] = '{
        INC_NARROW_W, INC_NARROW_W, INC_NARROW_W,
        INC_DATA_W, INC_DATA_W};

    // ****************************************************
    // Link timing
    // ****************************************************
    localparam int INC_CLK_PERIOD_NS = 8;
    localparam int INC_SCLK_MIN_PERIOD_NS = 1000;
    localparam int INC_SCLK_HALF_CYC =
        (INC_SCLK_MIN_PERIOD_NS / 2 + INC_CLK_PERIOD_NS - 1)
        / INC_CLK_PERIOD_NS;
    localparam int INC_FRAME_PERIOD_NS = 100000;
    localparam int INC_FRAME_PERIOD_CYC =
        (INC_FRAME_PERIOD_NS + INC_CLK_PERIOD_NS - 1) / INC_CLK_PERIOD_NS;
    localparam int INC_TIMER_W = 16;

endpackage

// [verilog/inc_spi_if.sv]
// Serial link between the host end and the inclinometer port end.
// Assumes only the host side drives select, clock and data in; the
// data-out wire idles high
// through a modelled pull-up when the device end lets it go.

`timescale 1ns/1ns

interface inc_spi_if;

    // Link wires
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_line;

    // Resolved level of the data-out wire
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input cs_n,
        input sclk,
        input din,
        output dout,
        output dout_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output din,
        input dout_line
    );

endinterface

// [verilog/inc_sync2.sv]
// Two-flop level synchroniser.
// Assumes the input is a level that stays put for several clocks.

`timescale 1ns/1ns

module inc_sync2 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Level
    input wire logic d_in,
    output logic q_out
);

    logic meta;

    // First flop feeds only the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end

endmodule

// [verilog/inc_dev_end.sv]
// Inclinometer serial port, device end: link-side shifter on the
// serial clock and the result registers on the core clock.
// Assumes the host frames with chip select, idles the serial clock
// high, and leaves at least tens of microseconds between frames.

`timescale 1ns/1ns

module inc_dev_end
    import inc_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Serial link
    inc_spi_if.dev spi,
    // Measurement results
    input wire logic [INC_NUM_RES-1:0] res_update_in,
    input wire logic [INC_NUM_RES-1:0][INC_DATA_W-1:0] res_value_in,
    input wire logic alarm_in,
    // Byte writes from the host
    output logic wr_strobe_out,
    output logic [INC_ADDR_W-1:0] wr_addr_out,
    output logic [INC_BYTE_W-1:0] wr_data_out,
    // Fresh flags of the result registers
    output logic [INC_NUM_RES-1:0] fresh_out
);

    // ****************************************************
    // Declarations
    // ****************************************************
    logic [INC_CNT_W-1:0] rise_cnt;
    logic [3:0] out_idx;
    logic [INC_FRAME_BITS-1:0] rx_shift;
    logic [INC_FRAME_BITS-1:0] cmd_word;
    logic req_tgl;
    logic req_sync;
    logic req_seen;
    logic req_evt;
    logic cmd_is_wr;
    logic cmd_is_rd;
    logic rd_evt;
    inc_addr_t cmd_addr;
    logic [INC_FRAME_BITS-1:0] resp_word;
    logic [INC_FRAME_BITS-1:0] next_resp;
    logic [INC_FRAME_BITS-1:0] res_word [INC_NUM_RES];

    // True when a byte address names result register idx
    function automatic logic inc_hit(input inc_addr_t addr, input int idx);
        inc_addr_t base;
        base = INC_RES_ADDR[idx];
        return addr[INC_ADDR_W-1:1] == base[INC_ADDR_W-1:1];
    endfunction

    // ****************************************************
    // Link side, serial clock domain
    // ****************************************************

    // Rising edge count; held clear while deselected
    always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            rise_cnt <= '0;
        end else if (rise_cnt != INC_FRAME_CNT) begin
            rise_cnt <= rise_cnt + 1'b1;
        end
    end

    // Input shift on rising edges, MSB first
    always_ff @(posedge spi.sclk) begin
        if (!spi.cs_n && rise_cnt != INC_FRAME_CNT) begin
            rx_shift <= {rx_shift[INC_FRAME_BITS-2:0], spi.din};
        end
    end

    // Whole command captured on the sixteenth rising edge
    always_ff @(posedge spi.sclk or posedge rst_in) begin
        if (rst_in) begin
            cmd_word <= '0;
            req_tgl <= 1'b0;
        end else if (!spi.cs_n && rise_cnt == INC_LAST_CNT) begin
            cmd_word <= {rx_shift[INC_FRAME_BITS-2:0], spi.din};
            req_tgl <= ~req_tgl;
        end
    end

    // Output index: first falling edge keeps the MSB, later ones advance
    always_ff @(negedge spi.sclk or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            out_idx <= '0;
        end else if (rise_cnt != INC_FRAME_CNT) begin
            out_idx <= rise_cnt[3:0];
        end
    end

    // Data out from the held response; MSB shows as soon as selected
    assign spi.dout = resp_word[INC_MSB_IDX - out_idx];
    assign spi.dout_oe = ~spi.cs_n;

    // ****************************************************
    // Crossing into the core clock domain
    // ****************************************************
    inc_sync2 u_req_sync (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .d_in(req_tgl),
        .q_out(req_sync)
    );

    // Remember the last toggle level handled
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            req_seen <= 1'b0;
        end else begin
            req_seen <= req_sync;
        end
    end

    // Command decode; the word is stable once the toggle is seen
    assign req_evt = req_sync ^ req_seen;
    assign cmd_is_wr = cmd_word[INC_CMD_WR_BIT] &&
                       !cmd_word[INC_CMD_MODE_BIT];
    assign cmd_is_rd = !cmd_word[INC_CMD_WR_BIT] &&
                       !cmd_word[INC_CMD_MODE_BIT];
    assign cmd_addr = cmd_word[INC_ADDR_HI:INC_ADDR_LO];
    assign rd_evt = req_evt && cmd_is_rd;

    // ****************************************************
    // Result registers
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < INC_NUM_RES; g++) begin : g_res
            logic [INC_DATA_W-1:0] data;
            logic fresh;
            logic [INC_DATA_W-1:0] value;

            // Narrow results keep their top two bits at zero
            assign value = (INC_RES_WIDTH[g] == INC_DATA_W) ?
                res_value_in[g] :
                {2'h0, res_value_in[g][INC_NARROW_W-1:0]};

            // Refresh at the result rate; an update beats a read clear
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    data <= '0;
                    fresh <= 1'b0;
                end else if (res_update_in[g]) begin
                    data <= value;
                    fresh <= 1'b1;
                end else if (rd_evt && inc_hit(cmd_addr, g)) begin
                    fresh <= 1'b0;
                end
            end

            // Register word: fresh, alarm, result
            assign res_word[g] = {fresh, alarm_in, data};
            assign fresh_out[g] = fresh;
        end
    endgenerate

    // ****************************************************
    // Response selection
    // ****************************************************

    // Pick the addressed register; unmapped addresses answer zero
    always_comb begin
        next_resp = '0;
        for (int i = 0; i < INC_NUM_RES; i++) begin
            if (inc_hit(cmd_addr, i)) begin
                next_resp = res_word[i];
            end
        end
    end

    // Response for the next frame; non-read frames answer zero
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            resp_word <= '0;
        end else if (req_evt) begin
            resp_word <= cmd_is_rd ? next_resp : '0;
        end
    end

    // ****************************************************
    // Byte writes
    // ****************************************************

    // One byte per write frame is handed to the user side
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_strobe_out <= 1'b0;
        end else begin
            wr_strobe_out <= req_evt && cmd_is_wr;
        end
    end

    // Address and data of the last write frame
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_addr_out <= '0;
            wr_data_out <= '0;
        end else if (req_evt && cmd_is_wr) begin
            wr_addr_out <= cmd_addr;
            wr_data_out <= cmd_word[INC_BYTE_W-1:0];
        end
    end

endmodule

// [verilog/inc_host_end.sv]
// Inclinometer serial port, host end: makes chip select and the
// serial clock from the core clock and runs one 16-bit frame per
// command, returning the word shifted in.
// Assumes the user side issues commands on the core clock.

`timescale 1ns/1ns

module inc_host_end
    import inc_pkg::*;
#(
    parameter int SCLK_HALF_CYC = INC_SCLK_HALF_CYC,
    parameter int FRAME_PERIOD_CYC = INC_FRAME_PERIOD_CYC
) (
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Serial link
    inc_spi_if.host spi,
    // Frame requests
    input wire logic cmd_valid_in,
    input wire logic [INC_FRAME_BITS-1:0] cmd_word_in,
    output logic cmd_ready_out,
    // Frame answers
    output logic resp_valid_out,
    output logic [INC_FRAME_BITS-1:0] resp_word_out
);

    typedef enum {INC_IDLE, INC_LEAD, INC_LOW, INC_HIGH, INC_GAP} inc_st_e;

    localparam logic [INC_TIMER_W-1:0] HALF_LAST =
        INC_TIMER_W'(SCLK_HALF_CYC - 1);
    localparam logic [INC_TIMER_W-1:0] PERIOD_LAST =
        INC_TIMER_W'(FRAME_PERIOD_CYC - 1);

    inc_st_e state;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_s;
    logic [INC_TIMER_W-1:0] ph_cnt;
    logic [INC_TIMER_W-1:0] gap_cnt;
    logic [INC_CNT_W-1:0] bit_cnt;
    logic [INC_FRAME_BITS-1:0] tx_shift;
    logic [INC_FRAME_BITS-1:0] rx_shift;

    // Link pins straight from flops
    assign spi.cs_n = cs_n;
    assign spi.sclk = sclk;
    assign spi.din = mosi;

    // Data-out pin brought into the core domain
    inc_sync2 u_miso_sync (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .d_in(spi.dout_line),
        .q_out(miso_s)
    );

    // Spacing from one chip select fall to the next
    always_ff @(posedge core_clk_in) begin
        if (rst_in || state == INC_IDLE) begin
            gap_cnt <= '0;
        end else if (gap_cnt != PERIOD_LAST) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    // Frame sequencer
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= INC_IDLE;
            cs_n <= 1'b1;
            sclk <= 1'b1;
            mosi <= 1'b0;
            ph_cnt <= '0;
            bit_cnt <= '0;
            tx_shift <= '0;
            rx_shift <= '0;
            cmd_ready_out <= 1'b0;
            resp_valid_out <= 1'b0;
            resp_word_out <= '0;
        end else begin
            resp_valid_out <= 1'b0;
            case (state)
                INC_IDLE: begin
                    cmd_ready_out <= 1'b1;
                    if (cmd_valid_in && cmd_ready_out) begin
                        cmd_ready_out <= 1'b0;
                        tx_shift <= cmd_word_in;
                        mosi <= cmd_word_in[INC_FRAME_BITS-1];
                        cs_n <= 1'b0;
                        ph_cnt <= '0;
                        bit_cnt <= '0;
                        state <= INC_LEAD;
                    end
                end
                INC_LEAD: begin
                    ph_cnt <= ph_cnt + 1'b1;
                    if (ph_cnt == HALF_LAST) begin
                        ph_cnt <= '0;
                        sclk <= 1'b0;
                        state <= INC_LOW;
                    end
                end
                INC_LOW: begin
                    ph_cnt <= ph_cnt + 1'b1;
                    if (ph_cnt == HALF_LAST) begin
                        ph_cnt <= '0;
                        sclk <= 1'b1;
                        rx_shift <= {rx_shift[INC_FRAME_BITS-2:0], miso_s};
                        bit_cnt <= bit_cnt + 1'b1;
                        state <= INC_HIGH;
                    end
                end
                INC_HIGH: begin
                    ph_cnt <= ph_cnt + 1'b1;
                    if (ph_cnt == HALF_LAST) begin
                        ph_cnt <= '0;
                        if (bit_cnt == INC_FRAME_CNT) begin
                            cs_n <= 1'b1;
                            resp_valid_out <= 1'b1;
                            resp_word_out <= rx_shift;
                            state <= INC_GAP;
                        end else begin
                            sclk <= 1'b0;
                            tx_shift <= tx_shift << 1;
                            mosi <= tx_shift[INC_FRAME_BITS-2];
                            state <= INC_LOW;
                        end
                    end
                end
                INC_GAP: begin
                    if (gap_cnt == PERIOD_LAST) begin
                        state <= INC_IDLE;
                    end
                end
                default: begin
                    state <= INC_IDLE;
                end
            endcase
        end
    end

endmodule

// [tb/inc_link_chk.sv]
// Checker for the serial link between the host end and the device end.
// Assumes it sees the link wires sampled on the host's core clock.

`timescale 1ns/1ns

module inc_link_chk (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic dout_line
);

    // ****************************************************
    // Helper counters
    // ****************************************************
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    logic [4:0] rises;
    logic [8:0] low_cnt;

    // Rising serial clock edges within the frame
    always_ff @(posedge core_clk_in) begin
        if (rst_in || cs_n) begin
            rises <= 5'h00;
        end else if ($rose(sclk)) begin
            rises <= rises + 5'h01;
        end
    end

    // Cycles spent with chip select low
    always_ff @(posedge core_clk_in) begin
        if (rst_in || cs_n) begin
            low_cnt <= 9'h000;
        end else begin
            low_cnt <= low_cnt + 9'h001;
        end
    end

    // ****************************************************
    // Link assertions
    // ****************************************************
    a_oe_follows_cs: assert property (dout_oe == !cs_n)
        else $error("data out enable does not follow chip select");
    a_released_high: assert property (cs_n |-> dout_line)
        else $error("data out wire not released while deselected");
    a_gap_high: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("chip select gap too short");
    a_frame_sixteen: assert property ($rose(cs_n) |-> rises == 5'h10)
        else $error("frame did not hold sixteen clocks");
    a_low_length: assert property ($rose(cs_n) |->
        low_cnt >= 9'h106 && low_cnt <= 9'h10a)
        else $error("frame length off");
    a_low_bound: assert property (!cs_n |-> low_cnt < 9'h12c)
        else $error("chip select stuck low");
    a_msb_first_fall: assert property ($fell(cs_n) |->
        ##6 $stable(dout) [*8])
        else $error("first bit moved at first falling edge");
    a_dout_hold_rise: assert property (!cs_n && $rose(sclk) |->
        $stable(dout))
        else $error("data out changed at a rising edge");
    a_din_on_fall: assert property (!cs_n && !$fell(cs_n) &&
        $changed(din) |-> $fell(sclk))
        else $error("data in changed away from a falling edge");
    a_idle_clock_high: assert property (cs_n |-> sclk)
        else $error("serial clock not idle high");

endmodule

// [tb/inclinometer_spi_output_port_bench.sv]
// Bench joining the host end and the device end over the link, plus a
// second device end driven by hand with broken frames and one whole frame.
// Assumes the package constants and a 125 MHz core clock.

`timescale 1ns/1ns

module inclinometer_spi_output_port_bench;
    import inc_pkg::*;

    // ****************************************************
    // Signals
    // ****************************************************
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    logic [15:0] cmd_word_in = 16'h0000;
    logic cmd_ready_out, resp_valid_out, rdy_s, rv_s;
    logic [15:0] resp_word_out;
    logic [INC_NUM_RES-1:0] res_update_in = '0;
    logic [INC_NUM_RES-1:0][INC_DATA_W-1:0] res_value_in = '0;
    logic alarm_in = 1'b0;
    logic wr_strobe_out, wr_strobe_2;
    logic [5:0] wr_addr_out, wr_addr_2;
    logic [7:0] wr_data_out, wr_data_2;
    logic [INC_NUM_RES-1:0] fresh_out;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int strobes_2 = 0;
    logic [31:0] seed = 32'h00000055;
    logic [15:0] exp_q[$];
    logic [15:0] wr_q[$];
    logic [15:0] pend = 16'h0000;
    logic [15:0] last_cmd, sh_din, sh_dout, e;
    logic [13:0] val [INC_NUM_RES];
    logic [INC_NUM_RES-1:0] fresh_m = '0;

    inc_spi_if inc_spi_if_inst ();
    inc_spi_if inc_spi_if_inst_2 ();

    // ****************************************************
    // Instances
    // ****************************************************
    inc_host_end #(.SCLK_HALF_CYC(8), .FRAME_PERIOD_CYC(600))
        inc_host_end_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .spi(inc_spi_if_inst), .cmd_valid_in(cmd_valid_in),
        .cmd_word_in(cmd_word_in), .cmd_ready_out(cmd_ready_out),
        .resp_valid_out(resp_valid_out), .resp_word_out(resp_word_out));
    inc_dev_end inc_dev_end_inst (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .spi(inc_spi_if_inst),
        .res_update_in(res_update_in), .res_value_in(res_value_in),
        .alarm_in(alarm_in), .wr_strobe_out(wr_strobe_out),
        .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
        .fresh_out(fresh_out));
    inc_dev_end inc_dev_end_inst_2 (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .spi(inc_spi_if_inst_2), .res_update_in(5'h00),
        .res_value_in('0), .alarm_in(1'b0), .wr_strobe_out(wr_strobe_2),
        .wr_addr_out(wr_addr_2), .wr_data_out(wr_data_2), .fresh_out());
    inc_link_chk inc_link_chk_inst (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .cs_n(inc_spi_if_inst.cs_n),
        .sclk(inc_spi_if_inst.sclk), .din(inc_spi_if_inst.din),
        .dout(inc_spi_if_inst.dout), .dout_oe(inc_spi_if_inst.dout_oe),
        .dout_line(inc_spi_if_inst.dout_line));

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Answer the device should latch for a command, from the model
    function automatic logic [15:0] answer(input logic [15:0] c);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < INC_NUM_RES; i++) begin
            if (c[15:14] == 2'b00 && c[13:9] == INC_RES_ADDR[i][5:1]) begin
                w = {fresh_m[i], alarm_in, val[i]};
                if (INC_RES_WIDTH[i] == INC_NARROW_W) begin
                    w[13:12] = 2'b00;
                end
                fresh_m[i] = 1'b0;
            end
        end
        return w;
    endfunction

    // One host frame; notes the answer due in this frame
    task automatic frame(input logic [15:0] c);
        int n;
        exp_q.push_back(pend);
        if (c[15:14] == 2'b10) begin
            wr_q.push_back(c);
        end
        last_cmd = c;
        @(posedge core_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_word_in <= c;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (rdy_s !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            fails++;
        end
        cmd_valid_in <= 1'b0;
        pend = answer(c);
        n = 0;
        while (rv_s !== 1'b1 && n < 2000) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n >= 2000) begin
            fails++;
        end
        @(negedge core_clk_in);
        check({11'h000, fresh_out}, {11'h000, fresh_m});
    endtask

    // Refresh one result register
    task automatic refresh(input int i, input logic [13:0] v);
        @(posedge core_clk_in);
        res_value_in[i] <= v;
        res_update_in[i] <= 1'b1;
        @(posedge core_clk_in);
        res_update_in <= '0;
        val[i] = v;
        fresh_m[i] = 1'b1;
    endtask

    // Hand-driven frame on the second link, 30 ns serial clock
    task automatic bang(input logic [15:0] w, input int n, input logic s);
        @(posedge core_clk_in);
        #7;
        inc_spi_if_inst_2.cs_n <= !s;
        for (int b = 0; b < n; b++) begin
            #15;
            inc_spi_if_inst_2.sclk <= 1'b0;
            inc_spi_if_inst_2.din <= w[15-b];
            #15;
            inc_spi_if_inst_2.sclk <= 1'b1;
        end
        #15;
        inc_spi_if_inst_2.cs_n <= 1'b1;
        inc_spi_if_inst_2.din <= !inc_spi_if_inst_2.din;
        repeat (20) @(posedge core_clk_in);
        check({15'h0000, inc_spi_if_inst_2.dout_oe}, 16'h0000);
    endtask

    // ****************************************************
    // Clock, watchers and timeout
    // ****************************************************
    initial begin
        inc_spi_if_inst_2.cs_n = 1'b1;
        inc_spi_if_inst_2.sclk = 1'b1;
        inc_spi_if_inst_2.din = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    // Settled copies of the host handshake
    always @(negedge core_clk_in) begin
        rdy_s <= cmd_ready_out;
        rv_s <= resp_valid_out;
    end

    // Bits seen on the wires, most significant first
    always @(posedge inc_spi_if_inst.sclk) begin
        if (inc_spi_if_inst.cs_n === 1'b0) begin
            sh_din <= {sh_din[14:0], inc_spi_if_inst.din};
            sh_dout <= {sh_dout[14:0], inc_spi_if_inst.dout_line};
        end
    end

    // Compare results with the oldest notes
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles > 40000) begin
            fails++;
            summarize();
        end
        if (resp_valid_out === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
            check(resp_word_out, e);
            check(sh_dout, e);
            check(sh_din, last_cmd);
        end
        if (wr_strobe_out === 1'b1) begin
            e = wr_q.size() > 0 ? wr_q.pop_front() : 16'hxxxx;
            check({2'b10, wr_addr_out, wr_data_out}, e);
        end
        if (wr_strobe_2 === 1'b1) begin
            strobes_2++;
            check({2'b10, wr_addr_2, wr_data_2}, 16'hb35a);
        end
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        for (int i = 0; i < INC_NUM_RES; i++) begin
            r = xs();
            refresh(i, r[13:0]);
        end
        refresh(4, 14'h3fe7);
        // Pipelined reads, low bytes then high bytes
        for (int k = 0; k < 10; k++) begin
            r = xs();
            @(posedge core_clk_in);
            alarm_in <= r[8];
            if (k == 5) begin
                refresh(3, r[29:16]);
            end
            frame({2'b00, INC_RES_ADDR[k%5][5:1], k >= 5, r[7:0]});
        end
        r = xs();
        frame({2'b10, 6'h19, r[7:0]});
        frame({2'b10, 6'h18, r[15:8]});
        frame(16'hc0ff);
        frame(16'h3c00);
        frame(16'h0e55);
        frame(16'h0900);
        frame(16'h0000);
        bang(16'hb35a, 16, 1'b0);
        bang(16'hb35a, 15, 1'b1);
        bang(16'hb35a, 16, 1'b1);
        repeat (20) @(posedge core_clk_in);
        check(16'(strobes_2), 16'h0001);
        check(16'(exp_q.size() + wr_q.size()), 16'h0000);
        summarize();
    end

endmodule
